/* File: rtl/rca_pkg.sv */
package rca_pkg;

    // Register byte offsets.
    localparam logic [7:0] RCA_OFS_CTRL   = 8'h00;
    localparam logic [7:0] RCA_OFS_STATUS = 8'h04;
    localparam logic [7:0] RCA_OFS_IRQST  = 8'h08;
    localparam logic [7:0] RCA_OFS_IRQMSK = 8'h0C;

    // Control register fields.
    localparam int RCA_CTRL_REMEN = 0;

    // Status register fields.
    localparam int RCA_ST_MODE   = 0;
    localparam int RCA_ST_HELD   = 1;
    localparam int RCA_ST_SELEN  = 2;
    localparam int RCA_ST_LOST   = 3;
    localparam int RCA_ST_ID_LSB = 4;

    // Interrupt status and mask fields.
    localparam int RCA_EV_ACQ   = 0;
    localparam int RCA_EV_REL   = 1;
    localparam int RCA_EV_LOST  = 2;
    localparam int RCA_EV_PANRJ = 3;
    localparam int RCA_EV_REMRJ = 4;
    localparam int RCA_EV_W     = 5;

    // Reset values.
    localparam logic              RCA_RST_REMEN  = 1'b0;
    localparam logic [RCA_EV_W-1:0] RCA_RST_IRQMSK = 5'h00;

    // Release encodings seen on the command link.
    localparam logic [15:0] RCA_REL_REG  = 16'h03E8;
    localparam logic [15:0] RCA_REL_CMD  = 16'hFFF1;
    localparam logic [15:0] RCA_REL_DATA = 16'h0000;

    // Timing.
    localparam longint RCA_CLK_HZ      = 50000000;
    localparam longint RCA_WDOG_S      = 10;
    localparam longint RCA_WDOG_CYC    = RCA_WDOG_S * RCA_CLK_HZ;
    localparam longint RCA_BLINK_MS    = 100;
    localparam longint RCA_BLINK_CYC   = (RCA_BLINK_MS * RCA_CLK_HZ) / 1000;

endpackage : rca_pkg

/* File: rtl/rca_timeout.sv */
`timescale 1ns/1ps
`default_nettype none
module rca_timeout
    import rca_pkg::*;
#(
    parameter int unsigned CYCLES = 32'(RCA_WDOG_CYC)
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic run,
    input  wire logic restart,
    output logic      expired
);
    logic [31:0] count_r;
    logic [31:0] count_nxt;
    logic        expired_nxt;

    // The pulse fires once when the gap grows past the full count.
    always_comb begin
        count_nxt   = count_r;
        expired_nxt = 1'b0;
        if (!run || restart) begin
            count_nxt = '0;
        end else if (count_r == CYCLES - 32'd1) begin
            count_nxt   = CYCLES;
            expired_nxt = 1'b1;
        end else if (count_r < CYCLES) begin
            count_nxt = count_r + 32'd1;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            count_r <= '0;
            expired <= 1'b0;
        end else begin
            count_r <= count_nxt;
            expired <= expired_nxt;
        end
    end
endmodule : rca_timeout
`default_nettype wire

/* File: rtl/rca_blink.sv */
`timescale 1ns/1ps
`default_nettype none
module rca_blink
    import rca_pkg::*;
#(
    parameter int unsigned HALF = 32'(RCA_BLINK_CYC)
) (
    input  wire logic clk,
    input  wire logic resetn,
    output logic      phase
);
    logic [31:0] div_r;
    logic [31:0] div_nxt;
    logic        phase_nxt;

    always_comb begin
        div_nxt   = div_r + 32'd1;
        phase_nxt = phase;
        if (div_r == HALF - 32'd1) begin
            div_nxt   = '0;
            phase_nxt = ~phase;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            div_r <= '0;
            phase <= 1'b0;
        end else begin
            div_r <= div_nxt;
            phase <= phase_nxt;
        end
    end
endmodule : rca_blink
`default_nettype wire

/* File: rtl/remote_control_arbiter.sv */
`timescale 1ns/1ps
`default_nettype none
module remote_control_arbiter
    import rca_pkg::*;
#(
    parameter int unsigned WDOG_CYCLES  = 32'(RCA_WDOG_CYC),
    parameter int unsigned BLINK_CYCLES = 32'(RCA_BLINK_CYC),
    parameter int          SRC_W        = 4
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    // Register port.
    input  wire logic [7:0]       regAddr,
    input  wire logic [31:0]      regWdata,
    input  wire logic             regWr,
    input  wire logic             regRd,
    output logic      [31:0]      regRdata,
    // Decoded frames from the command link.
    input  wire logic             frameValid,
    input  wire logic [SRC_W-1:0] frameSrc,
    input  wire logic             frameIsWrite,
    input  wire logic             frameIsVendor,
    input  wire logic [15:0]      frameAddr,
    input  wire logic [15:0]      frameData,
    output logic                  frameAccept,
    output logic                  frameReject,
    // Local panel.
    input  wire logic             panelWriteReq,
    output logic                  panelWriteGrant,
    output logic                  panelWriteReject,
    // Network status inputs.
    input  wire logic             linkUpPin,
    input  wire logic             trafficPin,
    input  wire logic             supplyOkPin,
    input  wire logic             ipAssigned,
    // Indications.
    output logic                  remoteControlMode,
    output logic                  remoteBarOn,
    output logic                  selectorEnabled,
    output logic                  masterHeld,
    output logic      [SRC_W-1:0] masterId,
    output logic                  linkLed,
    output logic                  netLed,
    output logic                  irq
);
    // Pin synchronisers: stage one is read only by stage two.
    logic [2:0] pinMeta_r;
    logic [2:0] pinSync_r;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pinMeta_r <= 3'h0;
            pinSync_r <= 3'h0;
        end else begin
            pinMeta_r <= {supplyOkPin, trafficPin, linkUpPin};
            pinSync_r <= pinMeta_r;
        end
    end

    logic linkUp;
    logic traffic;
    logic supplyOk;

    assign linkUp   = pinSync_r[0];
    assign traffic  = pinSync_r[1];
    assign supplyOk = pinSync_r[2];

    // Arbitration state.
    logic             remEn_r;
    logic             remEn_nxt;
    logic             held_r;
    logic             held_nxt;
    logic [SRC_W-1:0] id_r;
    logic [SRC_W-1:0] id_nxt;
    logic             lost_r;
    logic             lost_nxt;
    logic             fAcc_nxt;
    logic             fRej_nxt;
    logic             pGnt_nxt;
    logic             pRej_nxt;
    logic             restart;
    logic             expired;
    logic [RCA_EV_W-1:0] ev;

    // Release decoding differs between the register and the vendor protocols.
    function automatic logic isRelease(input logic vendor, input logic [15:0] addr,
                                       input logic [15:0] data);
        if (vendor) begin
            isRelease = (addr == RCA_REL_CMD) && (data == RCA_REL_DATA);
        end else begin
            isRelease = (addr == RCA_REL_REG) && (data == RCA_REL_DATA);
        end
    endfunction : isRelease

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // Frame classification.
    logic fromMaster;
    logic relFrame;
    logic ctrlWr;
    logic dropOnSilence;

    assign fromMaster    = held_r && (frameSrc == id_r);
    assign relFrame      = frameIsWrite && isRelease(frameIsVendor, frameAddr, frameData);
    assign ctrlWr        = regWr && hit(regAddr, RCA_OFS_CTRL);
    // A frame from the holder in the very cycle of expiry keeps its rights.
    assign dropOnSilence = expired && held_r && !(frameValid && fromMaster);

    always_comb begin
        remEn_nxt = remEn_r;
        held_nxt  = held_r;
        id_nxt    = id_r;
        lost_nxt  = lost_r;
        fAcc_nxt  = 1'b0;
        fRej_nxt  = 1'b0;
        pGnt_nxt  = 1'b0;
        pRej_nxt  = 1'b0;
        restart   = 1'b0;
        ev        = '0;

        // The setting changes only by a software write, and not while a master holds control.
        if (ctrlWr && !held_r) begin
            remEn_nxt = regWdata[RCA_CTRL_REMEN];
        end

        // Display and menu browsing stay open; only edits are refused.
        if (panelWriteReq) begin
            if (remEn_r) begin
                pRej_nxt         = 1'b1;
                ev[RCA_EV_PANRJ] = 1'b1;
            end else begin
                pGnt_nxt = 1'b1;
            end
        end

        // Any frame from the holder, read or write, proves the link alive.
        if (frameValid && fromMaster) begin
            restart = 1'b1;
        end

        // Only write frames are answered; reads never earn a reply flag.
        if (frameValid && frameIsWrite) begin
            if (!remEn_r) begin
                fRej_nxt         = 1'b1;
                ev[RCA_EV_REMRJ] = 1'b1;
            end else if (fromMaster) begin
                fAcc_nxt = 1'b1;
                if (relFrame) begin
                    held_nxt       = 1'b0;
                    ev[RCA_EV_REL] = 1'b1;
                end
            end else if (!held_r && !relFrame) begin
                held_nxt       = 1'b1;
                id_nxt         = frameSrc;
                lost_nxt       = 1'b0;
                fAcc_nxt       = 1'b1;
                restart        = 1'b1;
                ev[RCA_EV_ACQ] = 1'b1;
            end else begin
                fRej_nxt         = 1'b1;
                ev[RCA_EV_REMRJ] = 1'b1;
            end
        end

        // Silence past the window drops the rights and frees the selector.
        if (dropOnSilence) begin
            held_nxt        = 1'b0;
            lost_nxt        = 1'b1;
            ev[RCA_EV_LOST] = 1'b1;
        end

        // Leaving remote mode never leaves a stale holder behind.
        if (!remEn_r) begin
            held_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            remEn_r          <= RCA_RST_REMEN;
            held_r           <= 1'b0;
            id_r             <= '0;
            lost_r           <= 1'b0;
            frameAccept      <= 1'b0;
            frameReject      <= 1'b0;
            panelWriteGrant  <= 1'b0;
            panelWriteReject <= 1'b0;
        end else begin
            remEn_r          <= remEn_nxt;
            held_r           <= held_nxt;
            id_r             <= id_nxt;
            lost_r           <= lost_nxt;
            frameAccept      <= fAcc_nxt;
            frameReject      <= fRej_nxt;
            panelWriteGrant  <= pGnt_nxt;
            panelWriteReject <= pRej_nxt;
        end
    end

    // The timer runs only while a master holds rights.
    rca_timeout #(
        .CYCLES (WDOG_CYCLES)
    ) u_wdog (
        .clk     (clk),
        .resetn  (resetn),
        .run     (held_r),
        .restart (restart),
        .expired (expired)
    );

    // Indications follow the registered state directly.
    assign remoteControlMode = remEn_r;
    assign remoteBarOn       = remEn_r;
    assign selectorEnabled   = !held_r;
    assign masterHeld        = held_r;
    assign masterId          = id_r;

    // Network lamps.
    logic blinkPhase;
    logic linkLed_nxt;
    logic netLed_nxt;

    rca_blink #(
        .HALF (BLINK_CYCLES)
    ) u_blink (
        .clk    (clk),
        .resetn (resetn),
        .phase  (blinkPhase)
    );

    // Dark without a link, steady on a quiet link, blinking with traffic.
    always_comb begin
        linkLed_nxt = 1'b0;
        if (linkUp) begin
            if (traffic) begin
                linkLed_nxt = blinkPhase;
            end else begin
                linkLed_nxt = 1'b1;
            end
        end

        netLed_nxt = supplyOk && ipAssigned;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            linkLed <= 1'b0;
            netLed  <= 1'b0;
        end else begin
            linkLed <= linkLed_nxt;
            netLed  <= netLed_nxt;
        end
    end

    // Interrupt status, mask and register reads.
    logic [RCA_EV_W-1:0] irqSt_r;
    logic [RCA_EV_W-1:0] irqSt_nxt;
    logic [RCA_EV_W-1:0] irqMsk_r;
    logic [RCA_EV_W-1:0] irqMsk_nxt;
    logic [31:0]         rdata_nxt;
    logic [31:0]         status;
    logic                irq_nxt;

    always_comb begin
        status                                     = 32'h0000_0000;
        status[RCA_ST_MODE]                        = remEn_r;
        status[RCA_ST_HELD]                        = held_r;
        status[RCA_ST_SELEN]                       = !held_r;
        status[RCA_ST_LOST]                        = lost_r;
        status[RCA_ST_ID_LSB +: SRC_W]             = id_r;

        irqMsk_nxt = irqMsk_r;
        if (regWr && hit(regAddr, RCA_OFS_IRQMSK)) begin
            irqMsk_nxt = regWdata[RCA_EV_W-1:0];
        end

        // A read clears the status, but an event in the same cycle stays set.
        irqSt_nxt = irqSt_r;
        if (regRd && hit(regAddr, RCA_OFS_IRQST)) begin
            irqSt_nxt = '0;
        end
        irqSt_nxt = irqSt_nxt | ev;

        // The line follows the status as it will stand after this edge.
        irq_nxt = |(irqSt_nxt & irqMsk_nxt);

        // Read data stand for one cycle only and are zero otherwise.
        rdata_nxt = 32'h0000_0000;
        if (regRd) begin
            unique case (regAddr)
                RCA_OFS_CTRL: begin
                    rdata_nxt[RCA_CTRL_REMEN] = remEn_r;
                end
                RCA_OFS_STATUS: begin
                    rdata_nxt = status;
                end
                RCA_OFS_IRQST: begin
                    rdata_nxt[RCA_EV_W-1:0] = irqSt_r;
                end
                RCA_OFS_IRQMSK: begin
                    rdata_nxt[RCA_EV_W-1:0] = irqMsk_r;
                end
                default: begin
                    rdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            irqSt_r  <= '0;
            irqMsk_r <= RCA_RST_IRQMSK;
            regRdata <= 32'h0000_0000;
            irq      <= 1'b0;
        end else begin
            irqSt_r  <= irqSt_nxt;
            irqMsk_r <= irqMsk_nxt;
            regRdata <= rdata_nxt;
            irq      <= irq_nxt;
        end
    end

    // The block answers frames only through accept and reject; it never starts an exchange.
endmodule : remote_control_arbiter
`default_nettype wire

/* File: tb/rca_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module rca_assertions
    import rca_pkg::*;
#(
    parameter int unsigned WDOG_CYCLES = 50
) (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWdata,
    input wire logic        regWr,
    input wire logic        frameValid,
    input wire logic [3:0]  frameSrc,
    input wire logic        frameIsWrite,
    input wire logic        frameIsVendor,
    input wire logic [15:0] frameAddr,
    input wire logic [15:0] frameData,
    input wire logic        frameAccept,
    input wire logic        frameReject,
    input wire logic        panelWriteReq,
    input wire logic        panelWriteGrant,
    input wire logic        panelWriteReject,
    input wire logic        remoteControlMode,
    input wire logic        remoteBarOn,
    input wire logic        selectorEnabled,
    input wire logic        masterHeld,
    input wire logic [3:0]  masterId
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic        ctrlOn;
    logic        ctrlOff;
    logic        rel;
    logic        holderFr;
    logic [31:0] idleCnt_r;
    logic [31:0] idleCnt_nxt;
    assign ctrlOn = regWr && regAddr == RCA_OFS_CTRL && regWdata[RCA_CTRL_REMEN];
    assign ctrlOff = regWr && regAddr == RCA_OFS_CTRL && !regWdata[RCA_CTRL_REMEN];
    assign rel = frameIsWrite && frameData == RCA_REL_DATA
        && frameAddr == (frameIsVendor ? RCA_REL_CMD : RCA_REL_REG);
    assign holderFr = masterHeld && frameValid && frameSrc == masterId;
    // Counts cycles that a held master has stayed silent.
    always_comb idleCnt_nxt = (!masterHeld || holderFr) ? 32'h0 : idleCnt_r + 32'h1;
    always_ff @(posedge clk) idleCnt_r <= resetn ? idleCnt_nxt : 32'h0;
    sequence s_relFrame; holderFr && rel; endsequence
    sequence s_dropped; frameAccept && !masterHeld; endsequence
    property p_release; s_relFrame |=> s_dropped; endproperty
    a_release: assert property (p_release) else $error("release ignored");
    property p_panelRej; panelWriteReq && remoteControlMode |=> panelWriteReject; endproperty
    a_panelRej: assert property (p_panelRej) else $error("panel edit allowed");
    property p_panelOk; panelWriteReq && !remoteControlMode |=> panelWriteGrant; endproperty
    a_panelOk: assert property (p_panelOk) else $error("panel edit refused");
    property p_bar; remoteBarOn == remoteControlMode; endproperty
    a_bar: assert property (p_bar) else $error("bar wrong");
    property p_enter; $rose(remoteControlMode) |-> $past(ctrlOn); endproperty
    a_enter: assert property (p_enter) else $error("mode entered");
    property p_leave; ctrlOff && !masterHeld |=> !remoteControlMode; endproperty
    a_leave: assert property (p_leave) else $error("mode kept");
    property p_one; masterHeld |-> remoteControlMode && !selectorEnabled; endproperty
    a_one: assert property (p_one) else $error("two sources");
    property p_lock; masterHeld && ctrlOff |=> remoteControlMode; endproperty
    a_lock: assert property (p_lock) else $error("lock broken");
    property p_wdog; idleCnt_r <= WDOG_CYCLES + 2; endproperty
    a_wdog: assert property (p_wdog) else $error("rights kept");
    property p_keep; holderFr && !rel |=> masterHeld; endproperty
    a_keep: assert property (p_keep) else $error("rights lost");
    property p_foreign;
        masterHeld && frameValid && frameIsWrite && frameSrc != masterId
            |=> frameReject && !frameAccept;
    endproperty
    a_foreign: assert property (p_foreign) else $error("foreign write");
endmodule : rca_assertions
`default_nettype wire

/* File: tb/rca_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rca_master_model (
    input wire logic         clk,
    output logic             frameValid,
    output logic      [3:0]  frameSrc,
    output logic             frameIsWrite,
    output logic             frameIsVendor,
    output logic      [15:0] frameAddr,
    output logic      [15:0] frameData,
    input wire logic         frameAccept,
    input wire logic         frameReject
);
    initial begin
        frameValid = 1'b0;
        frameSrc = 4'h0;
        frameIsWrite = 1'b0;
        frameIsVendor = 1'b0;
        frameAddr = 16'hFFFF;
        frameData = 16'hFFFF;
    end
    // Only this side starts an exchange; the block merely answers.
    task automatic send(input logic [3:0] s, input logic w, input logic v,
                        input logic [15:0] a, input logic [15:0] d,
                        output logic acc, output logic rej);
        @(posedge clk);
        frameValid <= 1'b1;
        frameSrc <= s;
        frameIsWrite <= w;
        frameIsVendor <= v;
        frameAddr <= a;
        frameData <= d;
        @(posedge clk);
        frameValid <= 1'b0;
        frameSrc <= ~s;
        frameAddr <= ~a;
        frameData <= ~d;
        #1;
        acc = frameAccept;
        rej = frameReject;
    endtask : send
endmodule : rca_master_model
`default_nettype wire

/* File: tb/remote_control_arbiter_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module remote_control_arbiter_tb_top
    import rca_pkg::*;
;
    localparam int WD = 50;
    logic clk = 1'b0, resetn = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, regRdata;
    logic regWr = 1'b0, regRd = 1'b0, panelWriteReq = 1'b0;
    logic frameValid, frameIsWrite, frameIsVendor, frameAccept, frameReject;
    logic [3:0] frameSrc, masterId;
    logic [15:0] frameAddr, frameData;
    logic linkUpPin = 1'b0, trafficPin = 1'b0, supplyOkPin = 1'b0, ipAssigned = 1'b0;
    logic panelWriteGrant, panelWriteReject, remoteControlMode, remoteBarOn;
    logic selectorEnabled, masterHeld, linkLed, netLed, irq;
    int miscompares = 0, compares = 0, n, t;
    always #10 clk = ~clk;
    remote_control_arbiter #(.WDOG_CYCLES(WD), .BLINK_CYCLES(4)) u_remote_control_arbiter (
        .clk, .resetn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .frameValid,
        .frameSrc, .frameIsWrite, .frameIsVendor, .frameAddr, .frameData, .frameAccept,
        .frameReject, .panelWriteReq, .panelWriteGrant, .panelWriteReject, .linkUpPin,
        .trafficPin, .supplyOkPin, .ipAssigned, .remoteControlMode, .remoteBarOn,
        .selectorEnabled, .masterHeld, .masterId, .linkLed, .netLed, .irq);
    rca_master_model u_rca_master_model (.clk, .frameValid, .frameSrc, .frameIsWrite,
        .frameIsVendor, .frameAddr, .frameData, .frameAccept, .frameReject);
    task automatic wrap_up();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk("read data", e, regRdata);
    endtask : rd
    task automatic pan(input logic g);
        @(posedge clk);
        panelWriteReq <= 1'b1;
        @(posedge clk);
        panelWriteReq <= 1'b0;
        #1;
        chk("grant", g, panelWriteGrant);
        chk("refusal", !g, panelWriteReject);
    endtask : pan
    task automatic fr(input logic [3:0] s, input logic w, input logic v,
                      input logic [15:0] a, input logic [15:0] d, input logic e);
        logic acc, rej;
        u_rca_master_model.send(s, w, v, a, d, acc, rej);
        chk("accept", e, acc);
        chk("reject", w && !e, rej);
    endtask : fr
    task automatic blink(input int c);
        logic p;
        t = 0;
        #1 p = linkLed;
        repeat (c) begin
            @(posedge clk);
            #1;
            if (linkLed !== p)
                t++;
            p = linkLed;
        end
    endtask : blink
    task automatic s_local();
        rd(RCA_OFS_STATUS, 32'h04);
        rd(8'h10, 32'h0);
        wr(RCA_OFS_STATUS, 32'hFF);
        pan(1'b1);
        fr(4'h3, 1'b1, 1'b0, 16'h0010, 16'h0001, 1'b0);
        rd(RCA_OFS_STATUS, 32'h04);
        rd(RCA_OFS_IRQST, 32'h10);
    endtask : s_local
    task automatic s_remote();
        wr(RCA_OFS_CTRL, 32'h1);
        chk("bar", 1'b1, remoteBarOn);
        pan(1'b0);
        chk("masked irq", 1'b0, irq);
        wr(RCA_OFS_IRQMSK, 32'h1F);
        @(posedge clk);
        #1 chk("irq", 1'b1, irq);
        rd(RCA_OFS_IRQST, 32'h08);
        @(posedge clk);
        #1 chk("cleared irq", 1'b0, irq);
        fr(4'h3, 1'b1, 1'b0, 16'h0010, 16'h0005, 1'b1);
        chk("selector", 1'b0, selectorEnabled);
        rd(RCA_OFS_STATUS, 32'h33);
        fr(4'h5, 1'b1, 1'b0, 16'h0010, 16'h0001, 1'b0);
        fr(4'h5, 1'b1, 1'b0, RCA_REL_REG, 16'h0000, 1'b0);
        wr(RCA_OFS_CTRL, 32'h0);
        rd(RCA_OFS_CTRL, 32'h1);
        rd(RCA_OFS_IRQST, 32'h11);
    endtask : s_remote
    task automatic s_release();
        for (int i = 0; i < 2; i++) begin
            fr(i ? 4'h7 : 4'h3, 1'b1, i[0], i ? RCA_REL_CMD : RCA_REL_REG, 16'h1, 1'b1);
            chk("held", 1'b1, masterHeld);
            fr(i ? 4'h7 : 4'h3, 1'b1, i[0], i ? RCA_REL_CMD : RCA_REL_REG, 16'h0, 1'b1);
            chk("released", 1'b0, masterHeld);
            rd(RCA_OFS_STATUS, i ? 32'h75 : 32'h35);
            fr(4'h7, 1'b1, 1'b0, 16'h0020, 16'h0001, 1'b1);
        end
        chk("holder id", 32'h7, masterId);
        rd(RCA_OFS_IRQST, 32'h03);
    endtask : s_release
    task automatic s_wdog();
        repeat (3) begin
            repeat (WD - 10) @(posedge clk);
            fr(4'h7, 1'b0, 1'b0, 16'h0010, 16'h0000, 1'b0);
            chk("kept", 1'b1, masterHeld);
        end
        for (n = 0; n < WD + 10 && masterHeld === 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk("expiry", WD + 1, n);
        if (n >= WD + 10)
            wrap_up();
        #1 chk("selector back", 1'b1, selectorEnabled);
        rd(RCA_OFS_STATUS, 32'h7D);
        wr(RCA_OFS_CTRL, 32'h0);
        chk("local", 1'b0, remoteControlMode);
        pan(1'b1);
        rd(RCA_OFS_IRQST, 32'h04);
    endtask : s_wdog
    task automatic s_leds();
        chk("net off", 1'b0, netLed);
        blink(8);
        chk("link dark", 32'h0, {t[30:0], linkLed});
        @(posedge clk);
        linkUpPin <= 1'b1;
        supplyOkPin <= 1'b1;
        repeat (6) @(posedge clk);
        blink(12);
        chk("link steady", 32'h1, {t[30:0], linkLed});
        chk("no address", 1'b0, netLed);
        @(posedge clk);
        trafficPin <= 1'b1;
        ipAssigned <= 1'b1;
        repeat (6) @(posedge clk);
        blink(16);
        chk("blinking", 1'b1, t >= 3 && t <= 5);
        chk("net on", 1'b1, netLed);
    endtask : s_leds
    task automatic s_reset();
        wr(RCA_OFS_CTRL, 32'h1);
        fr(4'h5, 1'b1, 1'b0, 16'h0010, 16'h0001, 1'b1);
        @(posedge clk);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        #1 chk("mode after reset", 1'b0, remoteControlMode);
        chk("held after reset", 1'b0, masterHeld);
        chk("selector after reset", 1'b1, selectorEnabled);
        chk("irq after reset", 1'b0, irq);
        rd(RCA_OFS_STATUS, 32'h04);
        rd(RCA_OFS_IRQMSK, 32'h0);
        pan(1'b1);
    endtask : s_reset
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        s_local();
        s_remote();
        s_release();
        s_wdog();
        s_leds();
        s_reset();
        wrap_up();
    end
endmodule : remote_control_arbiter_tb_top
bind remote_control_arbiter rca_assertions #(.WDOG_CYCLES(WDOG_CYCLES)) u_rca_assertions (
    .clk, .resetn, .regAddr, .regWdata, .regWr, .frameValid, .frameSrc, .frameIsWrite,
    .frameIsVendor, .frameAddr, .frameData, .frameAccept, .frameReject, .panelWriteReq,
    .panelWriteGrant, .panelWriteReject, .remoteControlMode, .remoteBarOn,
    .selectorEnabled, .masterHeld, .masterId);
`default_nettype wire
